// ==== mcr_cfg.svh ====
// Register offsets, reset values and command codes of the command unit.
// Assumes 7-bit register addresses and 16-bit register data.
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define MCR_ADDR_STATUS   7'h6A
`define MCR_ADDR_RUN      7'h70
`define MCR_ADDR_BRAKE    7'h71
`define MCR_ADDR_SAVE     7'h73
`define MCR_ADDR_RESTORE  7'h74
`define MCR_ADDR_SEARCH   7'h75
`define MCR_ADDR_UPDATE   7'h76

// ==========================================================================
// Reset values, codes and field positions
// ==========================================================================
`define MCR_CMD_RESET     16'h0000
`define MCR_STATUS_RESET  16'h0000
`define MCR_CMD_ON        16'h0001
`define MCR_SAVE_KEY      16'h0002
`define MCR_STATUS_RUN    0
`define MCR_RDATA_NONE    16'h0000

`endif

// ==== mcr_cmd_launch.sv ====
// One-shot command launcher: holds a request to the core until acknowledged.
// Assumes fire and ack come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module mcr_cmd_launch (
   input  wire logic clock,  // Core clock.
   input  wire logic rst,    // Asynchronous reset, active high.
   input  wire logic fire,   // One-cycle launch from a register write.
   input  wire logic ack,    // Core has taken the request.
   output logic      req     // Request level to the core.
);

   localparam mcr_pkg::mcr_lnc_state_t LNC_RESET = '{pend: 1'b0};

   mcr_pkg::mcr_lnc_state_t s_reg;
   mcr_pkg::mcr_lnc_state_t s_next;

   // A launch in the acknowledge cycle wins, so a new command is kept.
   always_comb begin
      s_next = s_reg;
      if (fire) begin
         s_next.pend = 1'b1;
      end else if (ack) begin
         s_next.pend = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_reg <= LNC_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign req = s_reg.pend;

endmodule // mcr_cmd_launch

`default_nettype wire

// ==== mcr_command_regs.sv ====
// Command register unit of a servo motor controller.
// Assumes the serial frame decoder hands over single-cycle register
// strobes on the core clock, and that the core acknowledges each action.
`timescale 1ns/1ns
`default_nettype none
`include "mcr_cfg.svh"

module mcr_command_regs #(
   parameter logic [1:0] POS_MODE_CODE = 2'h1,  // Position mode code.
   parameter logic [1:0] SPD_MODE_CODE = 2'h2   // Speed mode code.
) (
   input  wire logic                   CLOCK,     // Core clock.
   input  wire logic                   RST,       // Async reset, high.
   input  wire mcr_pkg::mcr_bus_req_t  REG_REQ,   // Register access.
   output mcr_pkg::mcr_bus_resp_t      REG_RESP,  // Read answer.
   input  wire logic [1:0]             OP_MODE,   // Operating mode.
   input  wire mcr_pkg::mcr_act_t      ACT_ACK,   // Core took action.
   output mcr_pkg::mcr_act_t           ACT_REQ,   // Action requests.
   output logic                        DRIVE_EN,  // Motor driven.
   output logic                        BRAKE_EN   // Motor braked.
);

   // ========================================================================
   // State
   // ========================================================================
   localparam mcr_pkg::mcr_top_state_t TOP_RESET = '{
      run:     `MCR_CMD_RESET,
      brake:   `MCR_CMD_RESET,
      save:    `MCR_CMD_RESET,
      restore: `MCR_CMD_RESET,
      search:  `MCR_CMD_RESET,
      update:  `MCR_CMD_RESET,
      rdata:   `MCR_RDATA_NONE,
      rvalid:  1'b0
   };

   mcr_pkg::mcr_top_state_t s_reg;
   mcr_pkg::mcr_top_state_t s_next;

   logic              wr_run;
   logic              wr_brake;
   logic              wr_save;
   logic              wr_restore;
   logic              wr_search;
   logic              wr_update;
   logic              mode_ok;
   logic              running;
   logic [15:0]       status_word;
   mcr_pkg::mcr_act_t fire;
   logic [3:0]        fire_vec;
   logic [3:0]        ack_vec;
   logic [3:0]        req_vec;

   // ========================================================================
   // Write decode
   // ========================================================================

   // Each strobe marks a write to one command register.
   assign wr_run     = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_RUN);
   assign wr_brake   = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_BRAKE);
   assign wr_save    = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_SAVE);
   assign wr_restore = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_RESTORE);
   assign wr_search  = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_SEARCH);
   assign wr_update  = REG_REQ.wr && (REG_REQ.addr == `MCR_ADDR_UPDATE);

   // Set-point updates only make sense under the position or speed loop.
   assign mode_ok = (OP_MODE == POS_MODE_CODE) ||
                    (OP_MODE == SPD_MODE_CODE);

   // Launch strobes; only the exact key starts a save, to guard the flash.
   always_comb begin
      fire         = '0;
      fire.save    = wr_save && (REG_REQ.wdata == `MCR_SAVE_KEY);
      fire.restore = wr_restore;
      fire.search  = wr_search;
      fire.update  = wr_update && mode_ok;
   end

   // ========================================================================
   // Status word
   // ========================================================================

   // Only the running flag is live; every other bit reads as zero.
   always_comb begin
      status_word = `MCR_STATUS_RESET;
      status_word[`MCR_STATUS_RUN] = running;
   end

   // ========================================================================
   // Register bank and read port
   // ========================================================================

   // Stores written values and builds the one-cycle-late read answer.
   always_comb begin
      s_next        = s_reg;
      s_next.rvalid = REG_REQ.rd;
      if (wr_run) begin
         s_next.run = REG_REQ.wdata;
      end
      if (wr_brake) begin
         s_next.brake = REG_REQ.wdata;
      end
      if (wr_save) begin
         s_next.save = REG_REQ.wdata;
      end
      if (wr_restore) begin
         s_next.restore = REG_REQ.wdata;
      end
      if (wr_search) begin
         s_next.search = REG_REQ.wdata;
      end
      if (wr_update) begin
         s_next.update = REG_REQ.wdata;
      end
      if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            `MCR_ADDR_STATUS:  s_next.rdata = status_word;
            `MCR_ADDR_RUN:     s_next.rdata = s_reg.run;
            `MCR_ADDR_BRAKE:   s_next.rdata = s_reg.brake;
            `MCR_ADDR_SAVE:    s_next.rdata = s_reg.save;
            `MCR_ADDR_RESTORE: s_next.rdata = s_reg.restore;
            `MCR_ADDR_SEARCH:  s_next.rdata = s_reg.search;
            `MCR_ADDR_UPDATE:  s_next.rdata = s_reg.update;
            default:           s_next.rdata = `MCR_RDATA_NONE;
         endcase
      end
   end

   // State register.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s_reg <= TOP_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign REG_RESP.valid = s_reg.rvalid;
   assign REG_RESP.data  = s_reg.rdata;

   // ========================================================================
   // Drive control
   // ========================================================================

   // Run and brake act on their stored levels.
   mcr_drive_ctrl u_drive (
      .clock    (CLOCK),
      .rst      (RST),
      .run_on   (s_reg.run == `MCR_CMD_ON),
      .brake_on (s_reg.brake == `MCR_CMD_ON),
      .drive_en (running),
      .brake_en (BRAKE_EN)
   );

   assign DRIVE_EN = running;

   // ========================================================================
   // One-shot action launchers
   // ========================================================================

   assign fire_vec = fire;
   assign ack_vec  = ACT_ACK;

   // One launcher per action holds its request until the core takes it.
   generate
      for (genvar i = 0; i < 4; i++) begin : g_act
         mcr_cmd_launch u_launch (
            .clock (CLOCK),
            .rst   (RST),
            .fire  (fire_vec[i]),
            .ack   (ack_vec[i]),
            .req   (req_vec[i])
         );
      end
   endgenerate

   assign ACT_REQ = mcr_pkg::mcr_act_t'(req_vec);

endmodule // mcr_command_regs

`default_nettype wire

// ==== mcr_command_regs_checker.sv ====
// Port assertions for the command register unit.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Checker
// ==========================================================================
module mcr_command_regs_checker (
   input wire logic                   CLOCK,     // Core clock.
   input wire logic                   RST,       // Async reset, high.
   input wire mcr_pkg::mcr_bus_req_t  REG_REQ,   // Register access.
   input wire mcr_pkg::mcr_bus_resp_t REG_RESP,  // Read answer.
   input wire logic [1:0]             OP_MODE,   // Operating mode.
   input wire mcr_pkg::mcr_act_t      ACT_ACK,   // Core took action.
   input wire mcr_pkg::mcr_act_t      ACT_REQ,   // Action requests.
   input wire logic                   DRIVE_EN,  // Motor driven.
   input wire logic                   BRAKE_EN   // Motor braked.
);
   // All properties share the core clock and stand still in reset.
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   property p_rd_answer;
      REG_REQ.rd |=> REG_RESP.valid;
   endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
   property p_no_stray;
      !REG_REQ.rd |=> !REG_RESP.valid;
   endproperty
   a_no_stray: assert property (p_no_stray)
      else $error("answer without read");
   property p_stop;
      REG_REQ.wr && REG_REQ.addr == 7'h70 && REG_REQ.wdata == 16'h0000
         |=> ##1 !DRIVE_EN;
   endproperty
   a_stop: assert property (p_stop)
      else $error("motor not stopped");
   property p_brake;
      REG_REQ.wr && REG_REQ.addr == 7'h71 && REG_REQ.wdata == 16'h0001
         |=> ##1 BRAKE_EN && !DRIVE_EN;
   endproperty
   a_brake: assert property (p_brake)
      else $error("motor not braked");
   property p_save;
      REG_REQ.wr && REG_REQ.addr == 7'h73 && REG_REQ.wdata == 16'h0002
         |=> ACT_REQ.save;
   endproperty
   a_save: assert property (p_save)
      else $error("save not requested");
   property p_save_rel;
      ACT_REQ.save && ACT_ACK.save && !(REG_REQ.wr && REG_REQ.addr == 7'h73)
         |=> !ACT_REQ.save;
   endproperty
   a_save_rel: assert property (p_save_rel)
      else $error("save request held after ack");
   property p_restore;
      REG_REQ.wr && REG_REQ.addr == 7'h74 |=> ACT_REQ.restore;
   endproperty
   a_restore: assert property (p_restore)
      else $error("restore not requested");
   property p_search;
      REG_REQ.wr && REG_REQ.addr == 7'h75 |=> ACT_REQ.search;
   endproperty
   a_search: assert property (p_search)
      else $error("search not requested");
   property p_update;
      REG_REQ.wr && REG_REQ.addr == 7'h76 && OP_MODE inside {2'h1, 2'h2}
         |=> ACT_REQ.update;
   endproperty
   a_update: assert property (p_update)
      else $error("update not requested");
   property p_status;
      REG_REQ.rd && REG_REQ.addr == 7'h6A
         |=> REG_RESP.data == {15'h0000, $past(DRIVE_EN)};
   endproperty
   a_status: assert property (p_status)
      else $error("status word wrong");
   property p_excl;
      DRIVE_EN |-> !BRAKE_EN;
   endproperty
   a_excl: assert property (p_excl)
      else $error("driven while braked");
endmodule // mcr_command_regs_checker

bind mcr_command_regs mcr_command_regs_checker chk_i (.CLOCK(CLOCK),
   .RST(RST), .REG_REQ(REG_REQ), .REG_RESP(REG_RESP), .OP_MODE(OP_MODE),
   .ACT_ACK(ACT_ACK), .ACT_REQ(ACT_REQ), .DRIVE_EN(DRIVE_EN),
   .BRAKE_EN(BRAKE_EN));

`default_nettype wire

// ==== mcr_command_regs_tb.sv ====
// Self-checking testbench of the command register unit.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Testbench
// ==========================================================================
module mcr_command_regs_tb;
   logic                   clock = 1'b0;
   logic                   rst = 1'b1;
   logic [1:0]             op_mode = 2'h0;
   logic [3:0]             ack = 4'h0;
   logic [3:0]             act_req;
   mcr_pkg::mcr_bus_req_t  req;
   mcr_pkg::mcr_bus_resp_t resp;
   logic                   drive_en;
   logic                   brake_en;
   int                     failures = 0;
   int                     tests_run = 0;

   // Core clock, 4 ns period.
   always #2 clock = ~clock;

   mcr_host host (.clock(clock), .resp(resp), .req(req));
   mcr_command_regs uut (.CLOCK(clock), .RST(rst), .REG_REQ(req),
      .REG_RESP(resp), .OP_MODE(op_mode),
      .ACT_ACK(mcr_pkg::mcr_act_t'(ack)), .ACT_REQ(act_req),
      .DRIVE_EN(drive_en), .BRAKE_EN(brake_en));

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   // Reads a register and checks the answer strobe and the word.
   task automatic rchk(input logic [6:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic v;
      host.rd(a, d, v);
      chk("rd_valid", 16'h0001, 16'(v));
      chk("rd_data", e, d);
   endtask

   // Writes a level command and checks the drive outputs two edges on.
   task automatic drv(input logic [6:0] a, input logic [15:0] d,
                      input logic de, input logic be);
      host.wr(a, d);
      @(negedge clock);
      chk("drive_en", 16'(de), 16'(drive_en));
      chk("brake_en", 16'(be), 16'(brake_en));
   endtask

   // Writes an action command, checks the request, acks it, checks release.
   task automatic act(input logic [6:0] a, input logic [15:0] d,
                      input int b, input logic e);
      host.wr(a, d);
      chk("act_req", 16'(e), 16'(act_req[b]));
      ack[b] = 1'b1;
      @(negedge clock);
      ack[b] = 1'b0;
      chk("act_rel", 16'h0000, 16'(act_req[b]));
   endtask

   // Reset values, unmapped access and idle action requests.
   task automatic t_reset();
      logic [6:0] regs [6] = '{7'h70, 7'h71, 7'h73, 7'h74, 7'h75, 7'h76};
      foreach (regs[i]) rchk(regs[i], 16'h0000);
      rchk(7'h6A, 16'h0000);
      host.wr(7'h72, 16'hFFFF);
      rchk(7'h72, 16'h0000);
      chk("act_idle", 16'h0000, 16'(act_req));
      $display("test reset done");
   endtask

   // Run, brake and their priority, with the status word.
   task automatic t_drive();
      drv(7'h70, 16'h0001, 1'b1, 1'b0);
      rchk(7'h6A, 16'h0001);
      drv(7'h71, 16'h0001, 1'b0, 1'b1);
      rchk(7'h6A, 16'h0000);
      drv(7'h71, 16'h0000, 1'b1, 1'b0);
      drv(7'h70, 16'h0002, 1'b0, 1'b0);
      rchk(7'h70, 16'h0002);
      drv(7'h71, 16'h0001, 1'b0, 1'b1);
      drv(7'h70, 16'h0001, 1'b0, 1'b1);
      drv(7'h71, 16'h0000, 1'b1, 1'b0);
      drv(7'h70, 16'h0000, 1'b0, 1'b0);
      $display("test drive done");
   endtask

   // One-shot actions, the save key and the mode gate of update.
   task automatic t_act();
      act(7'h73, 16'h0002, 0, 1'b1);
      act(7'h73, 16'h0003, 0, 1'b0);
      act(7'h74, 16'h0000, 1, 1'b1);
      act(7'h75, 16'h1234, 2, 1'b1);
      act(7'h76, 16'h0001, 3, 1'b0);
      op_mode = 2'h1;
      act(7'h76, 16'h0001, 3, 1'b1);
      op_mode = 2'h2;
      act(7'h76, 16'h0001, 3, 1'b1);
      $display("test actions done");
   endtask

   // A reset in mid-run clears the commands and stops the motor.
   task automatic t_midreset();
      drv(7'h70, 16'h0001, 1'b1, 1'b0);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      chk("drive_rst", 16'h0000, 16'(drive_en));
      rst = 1'b0;
      rchk(7'h70, 16'h0000);
      rchk(7'h6A, 16'h0000);
      $display("test mid-run reset done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Main sequence after a 16-cycle reset.
   initial begin
      repeat (16) @(negedge clock);
      rst = 1'b0;
      t_reset();
      t_drive();
      t_act();
      t_midreset();
      report_and_stop();
   end

   // Watchdog: the tests need well under 1000 cycles.
   initial begin
      #20000;
      failures++;
      report_and_stop();
   end
endmodule // mcr_command_regs_tb

`default_nettype wire

// ==== mcr_drive_ctrl.sv ====
// Drive state machine: stop, run and brake from the two level commands.
// Assumes run_on and brake_on are decoded from registers on the same clock.
`timescale 1ns/1ns
`default_nettype none

module mcr_drive_ctrl (
   input  wire logic clock,     // Core clock.
   input  wire logic rst,       // Asynchronous reset, active high.
   input  wire logic run_on,    // Run command holds its on value.
   input  wire logic brake_on,  // Brake command holds its on value.
   output logic      drive_en,  // Motor is driven.
   output logic      brake_en   // Motor is braked.
);

   localparam mcr_pkg::mcr_drv_state_t DRV_RESET =
      '{st: mcr_pkg::MCR_DRV_STOP};

   mcr_pkg::mcr_drv_state_t s_reg;
   mcr_pkg::mcr_drv_state_t s_next;

   // Brake overrides run; releasing brake returns to run only if commanded.
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         mcr_pkg::MCR_DRV_STOP: begin
            if (brake_on) begin
               s_next.st = mcr_pkg::MCR_DRV_BRAKE;
            end else if (run_on) begin
               s_next.st = mcr_pkg::MCR_DRV_RUN;
            end
         end
         mcr_pkg::MCR_DRV_RUN: begin
            if (brake_on) begin
               s_next.st = mcr_pkg::MCR_DRV_BRAKE;
            end else if (!run_on) begin
               s_next.st = mcr_pkg::MCR_DRV_STOP;
            end
         end
         mcr_pkg::MCR_DRV_BRAKE: begin
            if (!brake_on) begin
               s_next.st = run_on ? mcr_pkg::MCR_DRV_RUN
                                  : mcr_pkg::MCR_DRV_STOP;
            end
         end
         default: begin
            s_next.st = mcr_pkg::MCR_DRV_STOP;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_reg <= DRV_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign drive_en = (s_reg.st == mcr_pkg::MCR_DRV_RUN);
   assign brake_en = (s_reg.st == mcr_pkg::MCR_DRV_BRAKE);

endmodule // mcr_drive_ctrl

`default_nettype wire

// ==== mcr_host.sv ====
// Host model: issues register writes and reads as the serial framer would.
// Assumes strobes are changed at the falling clock edge.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Host
// ==========================================================================
module mcr_host (
   input  wire logic                   clock,  // Core clock.
   input  wire mcr_pkg::mcr_bus_resp_t resp,   // Read answer.
   output var mcr_pkg::mcr_bus_req_t   req     // Register access.
);
   // Bus starts idle.
   initial req = '0;

   // One write strobe per command; released fields show inverted data.
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge clock);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // One read strobe; the answer is taken one cycle later.
   task automatic rd(input logic [6:0] a, output logic [15:0] d,
                     output logic v);
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge clock);
      req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
      d = resp.data;
      v = resp.valid;
   endtask
endmodule // mcr_host

`default_nettype wire

// ==== mcr_pkg.sv ====
// Types shared by the command register unit and its two helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package mcr_pkg;

   // =======================================================================
   // Register port carriers
   // =======================================================================
   typedef struct packed {
      logic        wr;     // One-cycle write strobe.
      logic        rd;     // One-cycle read strobe.
      logic [6:0]  addr;   // Register address.
      logic [15:0] wdata;  // Write data.
   } mcr_bus_req_t;

   typedef struct packed {
      logic        valid;  // One-cycle read answer strobe.
      logic [15:0] data;   // Read data.
   } mcr_bus_resp_t;

   // One bit per one-shot action handed to the core.
   typedef struct packed {
      logic update;   // Apply new set-points.
      logic search;   // Start the rotor angle offset search.
      logic restore;  // Reload parameters from non-volatile memory.
      logic save;     // Store parameters into non-volatile memory.
   } mcr_act_t;

   // =======================================================================
   // Drive state machine
   // =======================================================================
   typedef enum logic [1:0] {
      MCR_DRV_STOP  = 2'h0,
      MCR_DRV_RUN   = 2'h1,
      MCR_DRV_BRAKE = 2'h3
   } mcr_drv_st_t;

   typedef struct packed {
      mcr_drv_st_t st;
   } mcr_drv_state_t;

   typedef struct packed {
      logic pend;
   } mcr_lnc_state_t;

   typedef struct packed {
      logic [15:0] run;
      logic [15:0] brake;
      logic [15:0] save;
      logic [15:0] restore;
      logic [15:0] search;
      logic [15:0] update;
      logic [15:0] rdata;
      logic        rvalid;
   } mcr_top_state_t;

endpackage
